// >>> logic/sarcs_sequencer.sv
// Successive-approximation conversion sequencer with command decode and read path
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - An accepted convert enables the conversion clock and clears the whole register first.
// - A started conversion always runs to its end and is never aborted or restarted.
// - Result outputs stay disabled while a conversion is in progress.
// - The register tests the trial word one bit per conversion clock, MSB down to LSB in 12-bit mode, MSB down to bit 4 in 8-bit mode.
// - A trial bit is kept when the comparator says sum below input and cleared when above.
// - Deciding the last trial bit raises an end-of-conversion indication.
// - End of conversion stops the clock, drops the status output and re-enables reads.
// - After all bits the register holds the final result, which the read path shows.
// - Byte select sampled at start picks 12-bit when low and 8-bit when high.
// - Status goes high when a conversion begins and stays high until it completes.
// - Convert commands arriving during a conversion are ignored.
// - With enable high and select low, read-not-convert high reads and low converts.
module sarcs_sequencer #(
  parameter int unsigned CONV_DIV = sarcs_pkg::CONV_DIV
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        chip_enable_in,
  input  wire logic        chip_select_n_in,
  input  wire logic        read_not_convert_in,
  input  wire logic        length_byte_select_in,
  input  wire logic        word_format_12_in,
  input  wire logic        comparator_sum_below_in,
  output logic             conversion_status_out,
  output logic             conv_clk_en_out,
  output logic             end_of_conversion_out,
  output logic [11:0]      trial_word_out,
  output logic [11:0]      data_out,
  output logic [11:0]      data_oe_out
);
  // Bit period must cover the trial word flop and two comparator flops: keep CONV_DIV >= 4
  localparam int unsigned DIV_W = (CONV_DIV > 1) ? $clog2(CONV_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CONV_DIV - 1);

  // Host pins come from outside the clock domain
  // Select and read-not-convert reset high, so no command is seen after reset
  logic [1:0] ce_sync_r;
  logic [1:0] csn_sync_r;
  logic [1:0] rnc_sync_r;
  logic [1:0] bsel_sync_r;
  logic [1:0] fmt_sync_r;
  logic [1:0] cmp_sync_r;
  logic       ce_s;
  logic       csn_s;
  logic       rnc_s;
  logic       bsel_s;
  logic       fmt_s;
  logic       cmp_s;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ce_sync_r   <= 2'h0;
      csn_sync_r  <= 2'h3;
      rnc_sync_r  <= 2'h3;
      bsel_sync_r <= 2'h0;
      fmt_sync_r  <= 2'h0;
      cmp_sync_r  <= 2'h0;
    end else begin
      ce_sync_r   <= {ce_sync_r[0], chip_enable_in};
      csn_sync_r  <= {csn_sync_r[0], chip_select_n_in};
      rnc_sync_r  <= {rnc_sync_r[0], read_not_convert_in};
      bsel_sync_r <= {bsel_sync_r[0], length_byte_select_in};
      fmt_sync_r  <= {fmt_sync_r[0], word_format_12_in};
      cmp_sync_r  <= {cmp_sync_r[0], comparator_sum_below_in};
    end
  end

  assign ce_s   = ce_sync_r[1];
  assign csn_s  = csn_sync_r[1];
  assign rnc_s  = rnc_sync_r[1];
  assign bsel_s = bsel_sync_r[1];
  assign fmt_s  = fmt_sync_r[1];
  assign cmp_s  = cmp_sync_r[1];

  logic access_act;
  logic convert_cmd;
  logic read_cmd;
  assign access_act  = ce_s && !csn_s;
  assign convert_cmd = access_act && !rnc_s;
  assign read_cmd    = access_act && rnc_s;

  // Sequencer state
  sarcs_pkg::sarcs_state_t state_r;
  sarcs_pkg::sarcs_state_t state_nxt;
  logic [11:0]             approximation_register_r;
  logic [11:0]             approximation_register_nxt;
  logic [3:0]              bit_idx_r;
  logic [3:0]              bit_idx_nxt;
  logic                    short_conv_r;
  logic                    short_conv_nxt;
  logic [DIV_W-1:0]        div_cnt_r;
  logic [DIV_W-1:0]        div_cnt_nxt;
  logic                    status_r;
  logic                    status_nxt;
  logic                    eoc_r;
  logic                    eoc_nxt;
  logic                    conv_tick;
  logic [3:0]              last_idx;

  assign conv_tick = (div_cnt_r == DIV_LAST);
  assign last_idx  = short_conv_r ? sarcs_pkg::BIT_IDX_SHORT : 4'h0;

  always_comb begin
    state_nxt                  = state_r;
    approximation_register_nxt = approximation_register_r;
    bit_idx_nxt                = bit_idx_r;
    short_conv_nxt             = short_conv_r;
    div_cnt_nxt                = div_cnt_r;
    status_nxt                 = status_r;
    eoc_nxt                    = 1'b0;
    unique case (state_r)
      sarcs_pkg::SARCS_IDLE: begin
        div_cnt_nxt = '0;
        if (convert_cmd) begin
          state_nxt                  = sarcs_pkg::SARCS_CLEAR;
          approximation_register_nxt = sarcs_pkg::RESULT_RST;
          short_conv_nxt             = bsel_s;
          bit_idx_nxt                = sarcs_pkg::BIT_IDX_MSB;
          status_nxt                 = 1'b1;
        end
      end
      sarcs_pkg::SARCS_CLEAR: begin
        // Convert commands have no path out of the busy states
        state_nxt = sarcs_pkg::SARCS_TRIAL;
      end
      sarcs_pkg::SARCS_TRIAL: begin
        // Divider runs only here: the gated conversion clock
        div_cnt_nxt = conv_tick ? '0 : div_cnt_r + DIV_W'(1);
        if (conv_tick) begin
          // Comparator sampled at end of the trial period for settling
          approximation_register_nxt[bit_idx_r] = cmp_s;
          if (bit_idx_r == last_idx) begin
            state_nxt  = sarcs_pkg::SARCS_IDLE;
            eoc_nxt    = 1'b1;
            status_nxt = 1'b0;
          end else begin
            bit_idx_nxt = bit_idx_r - 4'h1;
          end
        end
      end
      default: begin
        // Unused state code falls back to idle rather than hanging busy
        state_nxt  = sarcs_pkg::SARCS_IDLE;
        status_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_r                  <= sarcs_pkg::SARCS_IDLE;
      approximation_register_r <= sarcs_pkg::RESULT_RST;
      bit_idx_r                <= sarcs_pkg::BIT_IDX_MSB;
      short_conv_r             <= 1'b0;
      div_cnt_r                <= '0;
      status_r                 <= 1'b0;
      eoc_r                    <= 1'b0;
    end else begin
      state_r                  <= state_nxt;
      approximation_register_r <= approximation_register_nxt;
      bit_idx_r                <= bit_idx_nxt;
      short_conv_r             <= short_conv_nxt;
      div_cnt_r                <= div_cnt_nxt;
      status_r                 <= status_nxt;
      eoc_r                    <= eoc_nxt;
    end
  end

  // Trial word shows the bit under test set on top of decided bits
  logic [11:0] trial_word;
  always_comb begin
    trial_word = approximation_register_r;
    if (state_r == sarcs_pkg::SARCS_TRIAL) begin
      trial_word[bit_idx_r] = 1'b1;
    end
  end

  // Read path; byte mode with byte select high puts low nibble left-justified with trailing zeros
  // Byte select is not latched: it must stay steady for the whole read
  logic [11:0] data_nxt;
  logic [11:0] data_r;
  logic [11:0] oe_nxt;
  logic [11:0] oe_r;
  always_comb begin
    data_nxt = data_r;
    oe_nxt   = 12'h000;
    if (read_cmd && state_r == sarcs_pkg::SARCS_IDLE) begin
      if (fmt_s) begin
        data_nxt = approximation_register_r;
        oe_nxt   = 12'hFFF;
      end else if (!bsel_s) begin
        data_nxt = {4'h0, approximation_register_r[11:4]};
        oe_nxt   = 12'h0FF;
      end else begin
        data_nxt = {4'h0, approximation_register_r[3:0], 4'h0};
        oe_nxt   = 12'h0FF;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      data_r     <= 12'h000;
      oe_r       <= 12'h000;
      trial_word_out <= 12'h000;
    end else begin
      data_r     <= data_nxt;
      oe_r       <= oe_nxt;
      trial_word_out <= trial_word;
    end
  end

  assign data_out              = data_r;
  assign data_oe_out           = oe_r;
  assign conversion_status_out = status_r;
  assign end_of_conversion_out = eoc_r;
  assign conv_clk_en_out       = (state_r == sarcs_pkg::SARCS_TRIAL);
endmodule
`default_nettype wire

// >>> logic/sarcs_pkg.sv
// Package of constants for the conversion sequencer
package sarcs_pkg;
  localparam int unsigned RESULT_W      = 12;
  localparam int unsigned SHORT_BITS    = 8;
  localparam int unsigned CLK_HZ        = 25000000;
  localparam int unsigned CONV_CLK_HZ   = 1000000;
  localparam int unsigned CONV_DIV      = CLK_HZ / CONV_CLK_HZ;
  localparam logic [11:0] RESULT_RST    = 12'h000;
  localparam logic [3:0]  BIT_IDX_MSB   = 4'hB;
  localparam logic [3:0]  BIT_IDX_SHORT = 4'h4;
  typedef enum logic [1:0] {
    SARCS_IDLE,
    SARCS_CLEAR,
    SARCS_TRIAL
  } sarcs_state_t;
endpackage

// >>> dv/sarcs_checker.sv
// Port assertions for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module sarcs_checker (
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire logic        conversion_status_out,
  input wire logic        conv_clk_en_out,
  input wire logic        end_of_conversion_out,
  input wire logic [11:0] trial_word_out,
  input wire logic [11:0] data_oe_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  eoc_drop_a: assert property (end_of_conversion_out |-> $past(conversion_status_out) &&
    !conversion_status_out && !conv_clk_en_out) else $error("eoc without stop");
  status_fall_a: assert property ($fell(conversion_status_out) |-> end_of_conversion_out)
    else $error("status fell early");
  start_word_a: assert property ($rose(conversion_status_out) |-> ##1
    trial_word_out == 12'h000 ##1 trial_word_out == 12'h800) else $error("no cleared start");
  clk_start_a: assert property ($rose(conversion_status_out) |=> conv_clk_en_out)
    else $error("clock not enabled");
  clk_busy_a: assert property (conv_clk_en_out |-> conversion_status_out)
    else $error("clock without status");
  busy_read_a: assert property (conversion_status_out |-> data_oe_out == 12'h000)
    else $error("read while busy");
  oe_shape_a: assert property (data_oe_out inside {12'h000, 12'h0FF, 12'hFFF})
    else $error("bad enable");
  eoc_pulse_a: assert property (end_of_conversion_out |=> !end_of_conversion_out)
    else $error("eoc too long");
  busy_hold_a: assert property ($rose(conversion_status_out) |-> conversion_status_out [*8])
    else $error("status short");
  cover property ($rose(conversion_status_out));
  cover property (end_of_conversion_out);
  cover property (data_oe_out == 12'h0FF);
  cover property (data_oe_out == 12'hFFF);
endmodule
bind sarcs_sequencer sarcs_checker sarcs_checker_inst (.clk_sys_in(clk_sys_in),
  .rst_n_in(rst_n_in), .conversion_status_out(conversion_status_out),
  .conv_clk_en_out(conv_clk_en_out), .end_of_conversion_out(end_of_conversion_out),
  .trial_word_out(trial_word_out), .data_oe_out(data_oe_out));
`default_nettype wire

// >>> dv/sarcs_comparator_model.sv
// Ideal comparator and analog level facing the trial word
`timescale 1ns/1ps
`default_nettype none
module sarcs_comparator_model (
  input wire logic [11:0] trial_word_in,
  input wire logic [11:0] level_in,
  output logic            sum_below_out
);
  // Ties read as below, so a 12-bit result lands on the level itself
  assign sum_below_out = (trial_word_in <= level_in);
endmodule
`default_nettype wire

// >>> dv/test_sarcs_sequencer.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module test_sarcs_sequencer;
  // Four cycles per bit cover the trial word flop and the comparator sync flops
  localparam int DIV = 4;
  logic clk_sys_in = 0, rst_n_in = 0, ce = 0, cs_n = 1, rnc = 1, bsel = 0, fmt = 1, below;
  logic sts, clk_en, eoc;
  logic [11:0] trial, dout, oe, lvl = 12'h000;
  int err_total = 0, checks = 0, hi_n = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) if (sts === 1'b1) hi_n++;
  sarcs_sequencer #(.CONV_DIV(DIV)) sarcs_sequencer_inst (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .chip_enable_in(ce), .chip_select_n_in(cs_n),
    .read_not_convert_in(rnc), .length_byte_select_in(bsel), .word_format_12_in(fmt),
    .comparator_sum_below_in(below), .conversion_status_out(sts), .conv_clk_en_out(clk_en),
    .end_of_conversion_out(eoc), .trial_word_out(trial), .data_out(dout), .data_oe_out(oe));
  sarcs_comparator_model sarcs_comparator_model_inst (.trial_word_in(trial), .level_in(lvl),
    .sum_below_out(below));
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys_in);
  endtask
  task automatic pins(input logic e, input logic r, input logic b);
    ce = e;
    cs_n = ~e;
    rnc = r;
    bsel = b;
  endtask
  task automatic wt(input logic v);
    for (int k = 0; k < 100 && sts !== v; k++) cyc(1);
    chk({11'h0, sts}, {11'h0, v});
  endtask
  task automatic half(input logic e, input logic s);
    ce = e;
    cs_n = s;
    rnc = 1'b0;
    cyc(6);
    chk({11'h0, sts}, 12'h000);
    ce = 1'b0;
    cs_n = 1'b1;
    cyc(2);
  endtask
  function automatic logic [11:0] res_of(input logic [11:0] v, input logic b);
    return b ? (v & 12'hFF0) : v;
  endfunction
  // One clear cycle, then one conversion clock per bit
  function automatic int exp_len(input logic b);
    return 1 + int'(b ? sarcs_pkg::SHORT_BITS : sarcs_pkg::RESULT_W) * DIV;
  endfunction
  task automatic rd(input logic f, input logic b, input logic [11:0] e, input logic [11:0] m);
    fmt = f;
    pins(1, 1, b);
    cyc(4);
    chk(oe, m);
    chk(dout & m, e);
    pins(0, 1, b);
    cyc(4);
  endtask
  task automatic conv(input logic [11:0] v, input logic b, input logic busy_ops);
    logic [11:0] r;
    r = res_of(v, b);
    lvl = v;
    hi_n = 0;
    pins(1, 0, b);
    wt(1'b1);
    pins(0, 0, b);
    chk({11'h0, sts}, 12'h001);
    if (busy_ops) begin
      pins(1, 1, 1'b0);
      cyc(4);
      chk(oe, 12'h000);
      pins(1, 0, ~b);
      cyc(3);
      pins(0, 0, b);
    end
    wt(1'b0);
    chk({10'h0, eoc, clk_en}, 12'h002);
    chk(12'(hi_n), 12'(exp_len(b)));
    rd(1, 0, r, 12'hFFF);
    rd(0, 0, {4'h0, r[11:4]}, 12'h0FF);
    rd(0, 1, {4'h0, r[3:0], 4'h0}, 12'h0FF);
  endtask
  task automatic complete_run;
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    complete_run;
  end
  initial begin
    void'($urandom(14243));
    cyc(8);
    rst_n_in = 1'b1;
    cyc(3);
    half(1'b1, 1'b1);
    half(1'b0, 1'b0);
    conv(12'hFFF, 1'b0, 1'b1);
    conv(12'h000, 1'b1, 1'b1);
    conv(12'h801, 1'b0, 1'b0);
    for (int i = 0; i < 16; i++) conv(12'($urandom), 1'($urandom), 1'($urandom));
    complete_run;
  end
endmodule
`default_nettype wire
